// ### dbs_device.sv
// Function
// [RQ1] At burst four, reads every second clock give gap-free data bursts.
// [RQ2] At burst eight, reads four clocks apart give continuous read data.
// [RQ3] Back-to-back bursts work for any banks, provided each was activated.
// [RQ4] Writes every second or fourth clock are accepted as continuous data.
// [RQ5] Read data starts additive latency plus CAS latency clocks after command.
// [RQ6] Write data starts one clock earlier than read latency.
// [RQ7] Controller leaves all banks idle before self refresh entry.
// [RQ8] Controller turns termination off tAOFD before self refresh entry. No termination signal is modelled.
// [RQ9] Controller re-enables termination only after tXSRD following exit. No termination signal is modelled.
// [RQ10] Controller waits tXSRD before reads, tXSNR before others, after exit.
// [RQ11] Controller issues only no-operation or deselect during self refresh. The testbench sends one stray read there, flagged on cmd_err.
`timescale 1ns/10ps
`default_nettype none
module dbs_device
(
   input wire logic clock,
   input wire logic rst_n,
   input wire logic link_clk,
   input wire logic cke,
   input wire logic cs_n,
   input wire logic ras_n,
   input wire logic cas_n,
   input wire logic we_n,
   input wire logic [dbs_pkg::BA_W-1:0] ba,
   input wire logic [dbs_pkg::ADDR_W-1:0] addr,
   input wire logic [dbs_pkg::DATA_W-1:0] dq_in,
   input wire logic [2:0] add_lat,
   input wire logic [2:0] cas_lat,
   input wire logic burst8,
   output logic [dbs_pkg::DATA_W-1:0] dq_out,
   output logic dq_oe,
   output logic dqs_out,
   output logic self_ref,
   output logic cmd_err,
   output logic wr_ready
);
   logic [dbs_pkg::PIN_W-1:0] s1_r, s2_r;
   logic link_d_r;
   logic rise, fall, beat, cke_s, cs_s, lk_s;
   logic [2:0] cmd_s;
   logic [dbs_pkg::BA_W-1:0] ba_s;
   logic [dbs_pkg::ADDR_W-1:0] addr_s;
   logic [dbs_pkg::DATA_W-1:0] dq_s;
   logic [dbs_pkg::LAT_W-1:0] rl, wl;
   logic [dbs_pkg::BEAT_W-1:0] bl;
   logic is_rd, is_wr, rd_ok, wr_ok, rd_start, wr_start;
   dbs_pkg::dbs_state_type st_r, st_nxt;
   logic [dbs_pkg::BANKS-1:0] bank_r, bank_nxt;
   logic [dbs_pkg::PEND_DEPTH-1:0] pr_r, pr_nxt, pw_r, pw_nxt;
   logic [dbs_pkg::COL_W-1:0] prc_r [dbs_pkg::PEND_DEPTH];
   logic [dbs_pkg::COL_W-1:0] prc_nxt [dbs_pkg::PEND_DEPTH];
   logic [dbs_pkg::COL_W-1:0] pwc_r [dbs_pkg::PEND_DEPTH];
   logic [dbs_pkg::COL_W-1:0] pwc_nxt [dbs_pkg::PEND_DEPTH];
   logic [dbs_pkg::BEAT_W-1:0] rd_left_r, rd_left_nxt, wr_left_r, wr_left_nxt;
   logic [dbs_pkg::COL_W-1:0] rd_col_r, rd_col_nxt, wr_col_r, wr_col_nxt;
   logic [dbs_pkg::DATA_W-1:0] dq_out_r, dq_out_nxt;
   logic dq_oe_r, dq_oe_nxt, dqs_r, dqs_nxt, err_r, err_nxt;
   logic [dbs_pkg::DATA_W-1:0] mem_r [dbs_pkg::MEM_DEPTH];
   logic [dbs_pkg::COL_W+dbs_pkg::DATA_W-1:0] fifo_r [dbs_pkg::FIFO_DEPTH];
   logic [dbs_pkg::COL_W+dbs_pkg::DATA_W-1:0] fifo_nxt [dbs_pkg::FIFO_DEPTH];
   logic fwp_r, fwp_nxt, frp_r, frp_nxt;
   logic [1:0] fcnt_r, fcnt_nxt;
   logic push, pop, rd_beat, wr_beat;

   // Two flops on every pin; the third link flop only feeds edge detection
   always_ff @(posedge clock or negedge rst_n)
   begin
      if (!rst_n)
      begin
         s1_r <= '0;
         s2_r <= '0;
         link_d_r <= 1'b0;
      end
      else
      begin
         s1_r <= {link_clk, cke, cs_n, ras_n, cas_n, we_n, ba, addr, dq_in};
         s2_r <= s1_r;
         link_d_r <= lk_s;
      end
   end

   // Decode of the synchronised pins
   assign {lk_s, cke_s, cs_s, cmd_s, ba_s, addr_s, dq_s} = s2_r;
   assign rise = lk_s & ~link_d_r;
   assign fall = ~lk_s & link_d_r;
   assign beat = rise | fall; // Double data rate: one beat per link edge
   assign rl = {1'b0, add_lat} + {1'b0, cas_lat};
   assign wl = rl - 4'h1;
   assign bl = burst8 ? dbs_pkg::BURST_LONG : dbs_pkg::BURST_SHORT;
   assign is_rd = rise & cke_s & ~cs_s & (cmd_s == dbs_pkg::CMD_READ);
   assign is_wr = rise & cke_s & ~cs_s & (cmd_s == dbs_pkg::CMD_WRITE);
   // [RQ3] open bank check
   assign rd_ok = is_rd & bank_r[ba_s] & (st_r == dbs_pkg::DBS_ST_IDLE);
   assign wr_ok = is_wr & bank_r[ba_s] & (st_r == dbs_pkg::DBS_ST_IDLE);
   assign rd_start = rise & pr_r[0];
   assign wr_start = rise & pw_r[0];
   assign rd_beat = beat & (rd_start | (rd_left_r != '0));
   assign wr_beat = beat & (wr_start | (wr_left_r != '0));
   // Array port is single; a read beat stalls the drain so the buffer fills
   assign push = wr_beat & (fcnt_r != 2'h2);
   assign pop = (fcnt_r != 2'h0) & ~rd_beat;
   assign wr_ready = (fcnt_r != 2'h2);

   // Bank open flags, one per bank
   genvar g;
   generate
      for (g = 0; g < dbs_pkg::BANKS; g++)
      begin : g_bank
         always_comb
         begin
            bank_nxt[g] = bank_r[g];
            if (rise && cke_s && !cs_s && (cmd_s == dbs_pkg::CMD_ACT) && (ba_s == g))
               bank_nxt[g] = 1'b1;
            else if (rise && cke_s && !cs_s && (cmd_s == dbs_pkg::CMD_PRE)
                     && (addr_s[dbs_pkg::PRE_ALL_BIT] || (ba_s == g)))
               bank_nxt[g] = 1'b0;
         end
      end
   endgenerate

   // Self refresh state; exit follows cke alone since the link clock may stop
   always_comb
   begin
      st_nxt = st_r;
      err_nxt = 1'b0;
      if (rise && !cs_s && (cmd_s != dbs_pkg::CMD_NOP) && cke_s
          && (is_rd || is_wr) && !bank_r[ba_s])
         err_nxt = 1'b1;
      case (st_r)
         dbs_pkg::DBS_ST_IDLE:
         begin
            if (rise && !cke_s && !cs_s && (cmd_s == dbs_pkg::CMD_REF))
               st_nxt = dbs_pkg::DBS_ST_SREF;
         end
         dbs_pkg::DBS_ST_SREF:
         begin
            if (rise && !cs_s && (cmd_s != dbs_pkg::CMD_NOP))
               err_nxt = 1'b1;
            if (cke_s)
               st_nxt = dbs_pkg::DBS_ST_IDLE;
         end
         default: st_nxt = dbs_pkg::DBS_ST_IDLE;
      endcase
   end

   // Latency queues and burst engines
   always_comb
   begin
      pr_nxt = pr_r;
      pw_nxt = pw_r;
      prc_nxt = prc_r;
      pwc_nxt = pwc_r;
      rd_left_nxt = rd_left_r;
      rd_col_nxt = rd_col_r;
      wr_left_nxt = wr_left_r;
      wr_col_nxt = wr_col_r;
      dq_out_nxt = dq_out_r;
      dq_oe_nxt = dq_oe_r;
      dqs_nxt = dqs_r;
      if (rise)
      begin
         pr_nxt = pr_r >> 1;
         pw_nxt = pw_r >> 1;
         for (int i = 0; i < dbs_pkg::PEND_DEPTH - 1; i++)
         begin
            prc_nxt[i] = prc_r[i+1];
            pwc_nxt[i] = pwc_r[i+1];
         end
         // [RQ5] read latency slot
         if (rd_ok)
         begin
            pr_nxt[rl-4'h1] = 1'b1;
            prc_nxt[rl-4'h1] = addr_s[dbs_pkg::COL_W-1:0];
         end
         // [RQ6] write latency slot
         if (wr_ok)
         begin
            pw_nxt[wl-4'h1] = 1'b1;
            pwc_nxt[wl-4'h1] = addr_s[dbs_pkg::COL_W-1:0];
         end
      end
      if (beat)
      begin
         dqs_nxt = rise;
         // [RQ1] [RQ2] new burst on the edge after the last beat, no gap
         if (rd_start)
         begin
            dq_out_nxt = mem_r[prc_r[0]];
            rd_col_nxt = prc_r[0] + 4'h1;
            rd_left_nxt = bl - 4'h1;
            dq_oe_nxt = 1'b1;
         end
         else if (rd_left_r != '0)
         begin
            dq_out_nxt = mem_r[rd_col_r];
            rd_col_nxt = rd_col_r + 4'h1;
            rd_left_nxt = rd_left_r - 4'h1;
         end
         else
            dq_oe_nxt = 1'b0;
         // [RQ4] write beats taken back to back
         if (wr_start)
         begin
            wr_col_nxt = pwc_r[0] + 4'h1;
            wr_left_nxt = bl - 4'h1;
         end
         else if (wr_left_r != '0)
         begin
            wr_col_nxt = wr_col_r + 4'h1;
            wr_left_nxt = wr_left_r - 4'h1;
         end
      end
   end

   // Two-entry write buffer between pins and array
   always_comb
   begin
      fifo_nxt = fifo_r;
      fwp_nxt = fwp_r;
      frp_nxt = frp_r;
      fcnt_nxt = fcnt_r;
      if (push)
      begin
         fifo_nxt[fwp_r] = {wr_start ? pwc_r[0] : wr_col_r, dq_s};
         fwp_nxt = ~fwp_r;
      end
      if (pop)
         frp_nxt = ~frp_r;
      fcnt_nxt = fcnt_r + {1'b0, push} - {1'b0, pop};
   end

   // Registers of all groups
   always_ff @(posedge clock or negedge rst_n)
   begin
      if (!rst_n)
      begin
         st_r <= dbs_pkg::DBS_ST_IDLE;
         err_r <= 1'b0;
         bank_r <= '0;
         pr_r <= '0;
         pw_r <= '0;
         prc_r <= '{default: '0};
         pwc_r <= '{default: '0};
         rd_left_r <= '0;
         rd_col_r <= '0;
         wr_left_r <= '0;
         wr_col_r <= '0;
         dq_out_r <= '0;
         dq_oe_r <= 1'b0;
         dqs_r <= 1'b0;
         fifo_r <= '{default: '0};
         fwp_r <= 1'b0;
         frp_r <= 1'b0;
         fcnt_r <= 2'h0;
      end
      else
      begin
         st_r <= st_nxt;
         err_r <= err_nxt;
         bank_r <= bank_nxt;
         pr_r <= pr_nxt;
         pw_r <= pw_nxt;
         prc_r <= prc_nxt;
         pwc_r <= pwc_nxt;
         rd_left_r <= rd_left_nxt;
         rd_col_r <= rd_col_nxt;
         wr_left_r <= wr_left_nxt;
         wr_col_r <= wr_col_nxt;
         dq_out_r <= dq_out_nxt;
         dq_oe_r <= dq_oe_nxt;
         dqs_r <= dqs_nxt;
         fifo_r <= fifo_nxt;
         fwp_r <= fwp_nxt;
         frp_r <= frp_nxt;
         fcnt_r <= fcnt_nxt;
      end
   end

   // Storage array, written from the buffer head; contents survive self refresh
   always_ff @(posedge clock or negedge rst_n)
   begin
      if (!rst_n)
         mem_r <= '{default: '0};
      else if (pop)
         mem_r[fifo_r[frp_r][dbs_pkg::COL_W+dbs_pkg::DATA_W-1:dbs_pkg::DATA_W]]
            <= fifo_r[frp_r][dbs_pkg::DATA_W-1:0];
   end

   assign dq_out = dq_out_r;
   assign dq_oe = dq_oe_r;
   assign dqs_out = dqs_r;
   assign self_ref = (st_r == dbs_pkg::DBS_ST_SREF);
   assign cmd_err = err_r;

   default clocking cb @(posedge clock); endclocking
   default disable iff (!rst_n);

   sequence last_rd_beat;
      beat && rd_left_r == 4'h1;
   endsequence

   read_short_gapless_a: assert property ( // [RQ1]
      (last_rd_beat ##0 !burst8 ##[2:8] rd_start) |=> dq_oe_r && rd_left_r == 4'h3)
      else $error("short read burst not seamless");
   read_long_length_a: assert property ( // [RQ2]
      (rd_start && burst8) |=> dq_oe_r && rd_left_r == 4'h7)
      else $error("long read burst length wrong");
   bank_closed_err_a: assert property ( // [RQ3]
      (is_rd && !bank_r[ba_s]) |=> cmd_err && !pr_r[$past(rl) - 4'h1])
      else $error("read to closed bank not flagged");
   write_burst_len_a: assert property ( // [RQ4]
      wr_start |=> wr_left_r == bl - 4'h1)
      else $error("write burst length wrong");
   read_latency_slot_a: assert property ( // [RQ5]
      rd_ok |=> pr_r[$past(rl) - 4'h1])
      else $error("read not queued at its latency");
   write_latency_slot_a: assert property ( // [RQ6]
      wr_ok |=> pw_r[$past(rl) - 4'h2])
      else $error("write not queued one clock before read latency");
endmodule
`default_nettype wire

// ### dbs_pkg.sv
package dbs_pkg;
   // Pin and storage widths
   localparam int DATA_W = 16;
   localparam int ADDR_W = 11;
   localparam int BA_W = 2;
   localparam int COL_W = 4;
   localparam int BANKS = 4;
   localparam int MEM_DEPTH = 16;
   localparam int PEND_DEPTH = 16;
   localparam int FIFO_DEPTH = 2;
   localparam int LAT_W = 4;
   localparam int BEAT_W = 4;
   // Precharge-all address bit
   localparam int PRE_ALL_BIT = 10;
   // Burst lengths in beats
   localparam logic [BEAT_W-1:0] BURST_SHORT = 4'h4;
   localparam logic [BEAT_W-1:0] BURST_LONG = 4'h8;
   // Command codes as {ras_n, cas_n, we_n}
   localparam logic [2:0] CMD_ACT = 3'h3;
   localparam logic [2:0] CMD_READ = 3'h5;
   localparam logic [2:0] CMD_WRITE = 3'h4;
   localparam logic [2:0] CMD_PRE = 3'h2;
   localparam logic [2:0] CMD_REF = 3'h1;
   localparam logic [2:0] CMD_NOP = 3'h7;
   // Sampled pin vector width: link clock, cke, cs_n, command, bank, address, data
   localparam int PIN_W = 1 + 1 + 1 + 3 + BA_W + ADDR_W + DATA_W;
   typedef enum logic [1:0]
   {
      DBS_ST_IDLE = 2'b01,
      DBS_ST_SREF = 2'b10
   } dbs_state_type;
endpackage

// ### dbs_ctrl_model.sv
`timescale 1ns/10ps
`default_nettype none
// Controller side of the link: issues queued commands and notes read beats
module dbs_ctrl_model
(
   input wire logic clock,
   output logic link_clk,
   output logic cke,
   output logic cs_n,
   output logic ras_n,
   output logic cas_n,
   output logic we_n,
   output logic [1:0] ba,
   output logic [10:0] addr,
   output logic [15:0] dq_in
);
   logic run = 1'b0;
   int ph = 4;
   int edge_n = 0;
   int rl = 5;
   int bl = 4;
   int err_exp = 0;
   logic [17:0] cq[$];
   logic [15:0] wq[$];
   logic [15:0] xd[$];
   int xe[$];
   logic [15:0] wbeat[int];
   logic [15:0] mem[16];
   logic [17:0] c = 18'h1e000;

   // Idle pins: deselected, link clock parked low
   initial
   begin
      {link_clk, cke, cs_n, ras_n, cas_n, we_n} = 6'h1f;
      ba = 2'h0;
      addr = 11'h000;
      dq_in = 16'h0000;
   end

   // One command per link clock, placed half a period before its rising edge
   task automatic issue();
      c = cq.size() != 0 ? cq.pop_front() : {1'b0, c[16], dbs_pkg::CMD_NOP, 13'h0};
      cke <= c[16];
      cs_n <= (c[15:13] == dbs_pkg::CMD_NOP);
      {ras_n, cas_n, we_n} <= c[15:13];
      ba <= c[12:11];
      addr <= c[10:0];
      // Refused commands bring no data, only an error pulse
      if (c[17])
         err_exp++;
      else if (c[15:14] == 2'h2)
         for (int j = 0; j < bl; j++)
         begin
            // read beats start RL link clocks on
            if (c[13])
            begin
               xd.push_back(mem[4'(c[3:0] + j)]);
               xe.push_back(edge_n + 1 + 2 * rl + j);
            end
            // write beats one link clock earlier
            else
            begin
               wbeat[edge_n + 2 * rl - 1 + j] = wq[0];
               mem[4'(c[3:0] + j)] = wq.pop_front();
            end
         end
   endtask

   // Link clock runs only inside a frame; idle data toggles so no stale word looks valid
   always @(negedge clock)
   begin
      if (run || ph != 4)
      begin
         ph = (ph + 1) % 8;
         if (ph == 0 || ph == 4)
         begin
            link_clk <= (ph == 0);
            edge_n++;
         end
         if (ph == 2 || ph == 6)
            dq_in <= wbeat.exists(edge_n + 1) ? wbeat[edge_n + 1] : ~dq_in;
         if (ph == 4)
            issue();
      end
   end
endmodule
`default_nettype wire

// ### dbs_device_tb_top.sv
`timescale 1ns/10ps
`default_nettype none
module dbs_device_tb_top;
   localparam int XSNR_LINKS = 4; // Exit wait in link clocks, a plain choice
   logic clock = 1'b0;
   logic rst_n = 1'b0;
   logic link_clk, cke, cs_n, ras_n, cas_n, we_n, dq_oe, dqs_out, self_ref, cmd_err;
   logic wr_ready, oe_q, dqs_q;
   logic [1:0] ba;
   logic [10:0] addr;
   logic [15:0] dq_in, dq_out;
   logic [2:0] add_lat = 3'h2;
   logic [2:0] cas_lat = 3'h3;
   logic burst8 = 1'b0;
   logic [6:0] cfg[3] = '{7'h26, 7'h27, 7'h04};
   logic [3:0] cols[4];
   logic [31:0] seed = 32'h3a52;
   int fails = 0;
   int compares = 0;
   int err_seen = 0;
   int stall_seen = 0;
   int cyc = 0;
   int d;

   dbs_ctrl_model cm (.clock(clock), .link_clk(link_clk), .cke(cke), .cs_n(cs_n),
      .ras_n(ras_n), .cas_n(cas_n), .we_n(we_n), .ba(ba), .addr(addr), .dq_in(dq_in));
   dbs_device dut_u (.clock(clock), .rst_n(rst_n), .link_clk(link_clk), .cke(cke),
      .cs_n(cs_n), .ras_n(ras_n), .cas_n(cas_n), .we_n(we_n), .ba(ba), .addr(addr),
      .dq_in(dq_in), .add_lat(add_lat), .cas_lat(cas_lat), .burst8(burst8),
      .dq_out(dq_out), .dq_oe(dq_oe), .dqs_out(dqs_out), .self_ref(self_ref),
      .cmd_err(cmd_err), .wr_ready(wr_ready));

   // 100 MHz system clock
   always #5 clock = ~clock;

   function automatic logic [31:0] xs();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction

   task automatic check(string name, logic [15:0] seen, logic [15:0] exp);
      compares++;
      if (seen !== exp)
      begin
         fails++;
         $display("FAIL %s expected %h seen %h", name, exp, seen);
      end
   endtask

   task automatic summarize();
      $display("compares %0d fails %0d", compares, fails);
      if (fails == 0 && compares > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask

   // Queue a command; writes also queue their random burst words
   task automatic send(logic bad, logic ce, logic [2:0] op, int b, int a);
      if (op == dbs_pkg::CMD_WRITE)
         repeat (cm.bl) cm.wq.push_back(16'(xs()));
      cm.cq.push_back({bad, ce, op, 2'(b), 11'(a)});
   endtask

   // Run the link until all queued work is out, bounded, then park it
   task automatic frame();
      int n;
      n = 0;
      @(negedge clock);
      cm.run = 1'b1;
      while ((cm.cq.size() != 0 || cm.xd.size() != 0) && n < 3000)
      begin
         @(negedge clock);
         n++;
      end
      check("drained", 16'(cm.xd.size()), 16'h0);
      repeat (40) @(negedge clock);
      cm.run = 1'b0;
      repeat (20) @(negedge clock);
   endtask

   // Each new beat is matched with the oldest noted beat, value and link edge
   always @(posedge clock)
   begin
      oe_q <= dq_oe;
      dqs_q <= dqs_out;
      if (cmd_err === 1'b1)
         err_seen++;
      if (wr_ready !== 1'b1 && rst_n)
         stall_seen++;
      if (dq_oe === 1'b1 && (oe_q !== 1'b1 || dqs_out !== dqs_q))
      begin
         if (cm.xd.size() == 0)
            check("spare_beat", 16'h1, 16'h0);
         else
         begin
            d = cm.edge_n - cm.xe.pop_front();
            check("rd_data", dq_out, cm.xd.pop_front());
            check("rd_edge", 16'(d inside {0, 1}), 16'h1);
         end
      end
   end

   // Hang guard well above the expected run length
   always @(posedge clock)
   begin
      cyc++;
      if (cyc == 15000)
      begin
         fails++;
         summarize();
      end
   end

   initial
   begin
      repeat (2) @(posedge clock);
      @(negedge clock);
      rst_n = 1'b1;
      @(negedge clock);
      check("oe_rst", dq_oe, 1'b0);
      check("ready_rst", wr_ready, 1'b1);
      // densest spacing at latency 5 for both burst lengths and at latency 2 for burst 4
      for (int k = 0; k < 3; k++)
      begin
         {add_lat, cas_lat, burst8} = cfg[k];
         cm.rl = add_lat + cas_lat;
         cm.bl = burst8 ? 8 : 4;
         for (int i = 0; i < 4; i++)
            cols[i] = 4'(xs());
         for (int b = 0; b < 4; b++)
            send(1'b0, 1'b1, dbs_pkg::CMD_ACT, b, 0);
         for (int rd = 0; rd < 2; rd++)
            for (int i = 0; i < 4; i++)
            begin
               send(1'b0, 1'b1, rd ? dbs_pkg::CMD_READ : dbs_pkg::CMD_WRITE, i, cols[i]);
               repeat (cm.bl / 2 - 1) send(1'b0, 1'b1, dbs_pkg::CMD_NOP, 0, 0);
            end
         frame();
      end
      // read to a closed bank, then entry with all banks idle
      send(1'b0, 1'b1, dbs_pkg::CMD_PRE, 0, 11'h400);
      send(1'b1, 1'b1, dbs_pkg::CMD_READ, 1, 0);
      send(1'b0, 1'b0, dbs_pkg::CMD_REF, 0, 0);
      frame();
      check("in_sref", self_ref, 1'b1);
      // stray read refused, exit, wait, then read
      send(1'b1, 1'b0, dbs_pkg::CMD_READ, 2, 0);
      repeat (XSNR_LINKS) send(1'b0, 1'b1, dbs_pkg::CMD_NOP, 0, 0);
      send(1'b0, 1'b1, dbs_pkg::CMD_ACT, 3, 0);
      send(1'b0, 1'b1, dbs_pkg::CMD_READ, 3, cols[0]);
      frame();
      check("out_sref", self_ref, 1'b0);
      check("err_cnt", 16'(err_seen), 16'(cm.err_exp));
      check("stalls", 16'(stall_seen), 16'h0);
      summarize();
   end
endmodule
`default_nettype wire
